// *** verilog/shs_pkg.sv ***
// package for the servo homing sequencer: register map, fields, reset values
// assumes a single drive control clock and an Avalon-MM register master
// Notes on behaviour
// RULE_01: hard-stop mode: stop, reverse, find index
// RULE_02: second stop before index fails homing
// RULE_03: index sets reference in any direction
// RULE_04: index modes need index-capable feedback
// RULE_05: capture unit latches index before start
// RULE_06: index mode drives in homing direction
// RULE_07: index loads both positions, then decelerate
// RULE_08: limit before index reverses, search continues
// RULE_09: home switch in homing direction sets reference
// RULE_10: stop flagged when error exceeds threshold
// RULE_11: current clamped during home-switch homing
// RULE_12: stop before switch: cross, reverse, retake
// RULE_13: capture modes select index latching
// RULE_14: motion tasks refused until homed
// RULE_15: busy, done and failed status shown
// RULE_16: switches used after single sync stage
`default_nettype none
package shs_pkg;
    localparam int unsigned ADDR_W = 4;
    // register word indices (byte address = 4 * index)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_HOMEP  = 4'h2;
    localparam logic [3:0] REG_THRESH = 4'h3;
    localparam logic [3:0] REG_ILIM   = 4'h4;
    localparam logic [3:0] REG_EVENT  = 4'h5;
    localparam logic [3:0] REG_MASK   = 4'h6;
    localparam logic [3:0] REG_CAPA   = 4'h7;
    localparam logic [3:0] REG_CAPB   = 4'h8;
    localparam logic [3:0] REG_POS    = 4'h9;
    // ctrl fields
    localparam int unsigned CTRL_START    = 0;
    localparam int unsigned CTRL_DIR      = 1;
    localparam int unsigned CTRL_MODE_LO  = 4;
    localparam int unsigned CTRL_TASK     = 8;
    localparam int unsigned CTRL_LOSE     = 9;
    // event bits
    localparam int unsigned EV_DONE   = 0;
    localparam int unsigned EV_FAIL   = 1;
    localparam int unsigned EV_STOP   = 2;
    localparam int unsigned EV_REFUSE = 3;
    localparam int unsigned EV_W      = 4;
    // homing modes
    localparam logic [3:0] MODE_STOP_INDEX = 4'ha;
    localparam logic [3:0] MODE_INDEX      = 4'hb;
    localparam logic [3:0] MODE_SWITCH     = 4'hc;
    // capture unit mode value that latches on the index
    localparam logic [1:0] CAP_ON_INDEX = 2'h1;
    // reset values
    localparam logic [31:0] RST_THRESH = 32'h0000_1000;
    localparam logic [15:0] RST_ILIM   = 16'h7fff;
    // wait before a search leg ends at standstill
    localparam int unsigned RAMP_NS     = 1000;
    localparam int unsigned CLK_NS      = 8;
    localparam int unsigned RAMP_CYCLES = (RAMP_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [2:0] {
        SHS_IDLE, SHS_SEEK, SHS_BACK, SHS_CROSS, SHS_RAMP, SHS_SETTLE
    } shs_state_e;
endpackage : shs_pkg
`default_nettype wire

// *** verilog/shs_regs.sv ***
// configuration register storage for the homing sequencer
// assumes the main module decodes the bus and drives the write strobes
`default_nettype none
module shs_regs
    import shs_pkg::*;
#(
    parameter int unsigned NREG = 4
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // write side
    input  wire logic [NREG-1:0]       wr_en,
    input  wire logic [31:0]           wr_data,
    // read side
    input  wire logic [$clog2(NREG)-1:0] rd_sel,
    output logic      [31:0]           rd_data_q,
    output logic      [NREG*32-1:0]    all_q
);
    logic [31:0] mem_q [NREG];
    initial begin
        assert (NREG >= 2) else $error("shs_regs needs two words");
    end
    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_word
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    mem_q[g] <= 32'h0;
                end else if (wr_en[g]) begin
                    mem_q[g] <= wr_data;
                end
            end
            assign all_q[g*32 +: 32] = mem_q[g];
        end
    endgenerate
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= 32'h0;
        end else begin
            rd_data_q <= mem_q[rd_sel];
        end
    end
endmodule : shs_regs
`default_nettype wire

// *** verilog/shs_sequencer.sv ***
// homing sequencer top: modes for stop-then-index, index search, home switch
// assumes position loop inputs synchronous to ref_clk, Avalon-MM master
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none
module shs_sequencer
    import shs_pkg::*;
#(
    parameter int unsigned POS_W = 32
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // feedback and position loop
    input  wire logic              index_pulse,
    input  wire logic [POS_W-1:0]  following_error,
    input  wire logic [POS_W-1:0]  feedback_position,
    input  wire logic              at_standstill,
    // switches
    input  wire logic              limit_pos,
    input  wire logic              limit_neg,
    input  wire logic              home_switch,
    // motion outputs
    output logic                   move_en,
    output logic                   move_dir,
    output logic                   decel_req,
    output logic                   pos_load,
    output logic      [POS_W-1:0]  commanded_position,
    output logic      [15:0]       homing_current_limit,
    output logic                   current_clamp,
    output logic                   task_start,
    output logic      [1:0]        capture_unit_a_mode,
    output logic      [1:0]        capture_unit_b_mode,
    // status
    output logic                   busy,
    output logic                   done,
    output logic                   failed,
    output logic                   irq
);
    initial begin
        assert (POS_W == 32) else $error("position width must be 32");
    end

    function automatic logic [POS_W-1:0] mag(input logic [POS_W-1:0] v);
        return v[POS_W-1] ? (~v + 1'b1) : v;
    endfunction : mag

    // register storage: homep, thresh, capa and capb share words 0..3
    logic [3:0]        store_we;
    logic [31:0]       store_rd_q;
    logic [127:0]      store_q;
    logic [31:0]       home_p;
    logic [31:0]       thresh_raw;
    logic [31:0]       thresh;
    logic [1:0]        sel2;
    shs_regs #(.NREG(4)) u_regs (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .wr_en     (store_we),
        .wr_data   (avs_writedata),
        .rd_sel    (sel2),
        .rd_data_q (store_rd_q),
        .all_q     (store_q)
    );
    assign home_p     = store_q[31:0];
    assign thresh_raw = store_q[63:32];
    // zero after reset means the default threshold
    assign thresh     = (thresh_raw == 32'h0) ? RST_THRESH : thresh_raw;

    logic [31:0]       ctrl_q;
    logic [EV_W-1:0]   ev_q;
    logic [EV_W-1:0]   mask_q;
    logic [EV_W-1:0]   ev_set;
    logic              rd_pend_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic              homed_q;
    logic              start_cmd;
    logic              task_cmd;
    logic              lose_cmd;
    logic [3:0]        mode;
    logic              dir_cfg;

    assign mode    = ctrl_q[CTRL_MODE_LO +: 4];
    assign dir_cfg = ctrl_q[CTRL_DIR];

    // store words: homep, thresh, capa, capb
    always_comb begin
        store_we = 4'h0;
        sel2     = 2'h0;
        if (avs_write && avs_waitrequest == 1'b0) begin
            store_we[0] = (avs_address == REG_HOMEP);
            store_we[1] = (avs_address == REG_THRESH);
            store_we[2] = (avs_address == REG_CAPA);
            store_we[3] = (avs_address == REG_CAPB);
        end
        // select from the live address so the stored word is ready when read data is taken
        unique case (avs_address)
            REG_THRESH: sel2 = 2'h1;
            REG_CAPA:   sel2 = 2'h2;
            REG_CAPB:   sel2 = 2'h3;
            default:    sel2 = 2'h0;
        endcase
    end

    logic wr_go;
    assign wr_go     = avs_write && !avs_waitrequest;
    assign start_cmd = wr_go && avs_address == REG_CTRL && avs_writedata[CTRL_START];
    assign task_cmd  = wr_go && avs_address == REG_CTRL && avs_writedata[CTRL_TASK];
    assign lose_cmd  = wr_go && avs_address == REG_CTRL && avs_writedata[CTRL_LOSE];

    // writes wait one cycle; reads wait two cycles for registered data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            rd_pend_q       <= 1'b0;
            rd_addr_q       <= '0;
        end else begin
            rd_pend_q       <= avs_read && avs_waitrequest && !rd_pend_q;
            rd_addr_q       <= avs_address;
            avs_waitrequest <= !((avs_write && avs_waitrequest)
                                 || (avs_read && rd_pend_q && avs_waitrequest));
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q               <= 32'h0;
            mask_q               <= '0;
            homing_current_limit <= RST_ILIM;
        end else if (wr_go) begin
            if (avs_address == REG_CTRL) begin
                ctrl_q <= avs_writedata & 32'h0000_00f2;
            end
            if (avs_address == REG_MASK) begin
                mask_q <= avs_writedata[EV_W-1:0];
            end
            if (avs_address == REG_ILIM) begin
                homing_current_limit <= avs_writedata[15:0];
            end
        end
    end

    // RULE_13 capture modes from registers
    // RULE_05 software sets index latching before start
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            capture_unit_a_mode <= 2'h0;
            capture_unit_b_mode <= 2'h0;
        end else begin
            capture_unit_a_mode <= store_q[65:64];
            capture_unit_b_mode <= store_q[97:96];
        end
    end

    // RULE_16 single sync stage, no debounce
    logic       lp_q, ln_q, hs_q, ix_q, hs_d1_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lp_q    <= 1'b0;
            ln_q    <= 1'b0;
            hs_q    <= 1'b0;
            ix_q    <= 1'b0;
            hs_d1_q <= 1'b0;
        end else begin
            lp_q    <= limit_pos;
            ln_q    <= limit_neg;
            hs_q    <= home_switch;
            ix_q    <= index_pulse;
            hs_d1_q <= hs_q;
        end
    end

    // RULE_10 mechanical stop on error magnitude
    logic mech_stop;
    assign mech_stop = mag(following_error) > thresh;

    logic limit_hit;
    assign limit_hit = move_dir ? lp_q : ln_q;
    logic hs_rise, hs_fall;
    assign hs_rise = hs_q && !hs_d1_q;
    assign hs_fall = !hs_q && hs_d1_q;

    shs_state_e state_q;
    logic       reversed_q;
    logic [$clog2(RAMP_CYCLES+1)-1:0] ramp_q;
    logic       ref_take, fail_take, ramp_done;
    assign ramp_done = (ramp_q == '0) && at_standstill;

    // RULE_03 index sets reference regardless of direction
    // RULE_09 switch in homing direction takes reference
    always_comb begin
        ref_take  = 1'b0;
        fail_take = 1'b0;
        if (state_q == SHS_SEEK || state_q == SHS_BACK) begin
            unique case (mode)
                MODE_STOP_INDEX: begin
                    ref_take  = state_q == SHS_BACK && ix_q;
                    // RULE_02 second stop aborts
                    fail_take = state_q == SHS_BACK && !ix_q && mech_stop;
                end
                MODE_INDEX:  ref_take = ix_q;
                MODE_SWITCH: ref_take = state_q == SHS_SEEK && hs_rise
                                        && move_dir == dir_cfg;
                default:     fail_take = 1'b1;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q    <= SHS_IDLE;
            move_en    <= 1'b0;
            move_dir   <= 1'b0;
            decel_req  <= 1'b0;
            reversed_q <= 1'b0;
            ramp_q     <= '0;
        end else begin
            unique case (state_q)
                SHS_IDLE: if (start_cmd) begin
                    // RULE_06 start in homing direction
                    state_q    <= SHS_SEEK;
                    move_en    <= 1'b1;
                    move_dir   <= avs_writedata[CTRL_DIR];
                    decel_req  <= 1'b0;
                    reversed_q <= 1'b0;
                end
                SHS_SEEK: begin
                    if (ref_take || fail_take) begin
                        state_q   <= SHS_RAMP;
                        decel_req <= 1'b1;
                        ramp_q    <= RAMP_CYCLES[$bits(ramp_q)-1:0];
                    end else if (mode == MODE_STOP_INDEX && mech_stop) begin
                        // RULE_01 hard stop found, reverse to index
                        state_q  <= SHS_BACK;
                        move_dir <= !move_dir;
                    end else if (mode == MODE_INDEX && limit_hit && !reversed_q) begin
                        // RULE_08 limit reverses index search
                        move_dir   <= !move_dir;
                        reversed_q <= 1'b1;
                    end else if (mode == MODE_SWITCH && mech_stop) begin
                        // RULE_12 stop before switch: back across it
                        state_q  <= SHS_CROSS;
                        move_dir <= !move_dir;
                    end
                end
                SHS_BACK: if (ref_take || fail_take) begin
                    state_q   <= SHS_RAMP;
                    decel_req <= 1'b1;
                    ramp_q    <= RAMP_CYCLES[$bits(ramp_q)-1:0];
                end
                SHS_CROSS: if (hs_fall) begin
                    // RULE_12 switch crossed: ramp down, then retry
                    state_q   <= SHS_SETTLE;
                    decel_req <= 1'b1;
                    ramp_q    <= RAMP_CYCLES[$bits(ramp_q)-1:0];
                end
                SHS_SETTLE: begin
                    if (ramp_q != '0) begin
                        ramp_q <= ramp_q - 1'b1;
                    end else if (at_standstill) begin
                        state_q   <= SHS_SEEK;
                        decel_req <= 1'b0;
                        move_dir  <= dir_cfg;
                    end
                end
                SHS_RAMP: begin
                    if (ramp_q != '0) begin
                        ramp_q <= ramp_q - 1'b1;
                    end
                    if (ramp_done) begin
                        state_q   <= SHS_IDLE;
                        move_en   <= 1'b0;
                        decel_req <= 1'b0;
                    end
                end
            endcase
        end
    end

    // RULE_07 load both positions at reference
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pos_load           <= 1'b0;
            commanded_position <= '0;
        end else begin
            pos_load <= ref_take;
            if (ref_take) begin
                commanded_position <= home_p;
            end
        end
    end

    // RULE_11 current clamp in switch mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            current_clamp <= 1'b0;
        end else begin
            current_clamp <= (state_q != SHS_IDLE) && mode == MODE_SWITCH;
        end
    end

    // RULE_15 busy, done, failed
    // RULE_14 homed flag gates task starts
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy       <= 1'b0;
            done       <= 1'b0;
            failed     <= 1'b0;
            homed_q    <= 1'b0;
            task_start <= 1'b0;
        end else begin
            busy       <= (state_q != SHS_IDLE && !(state_q == SHS_RAMP && ramp_done))
                          || (state_q == SHS_IDLE && start_cmd);
            task_start <= task_cmd && homed_q && state_q == SHS_IDLE;
            if (start_cmd && state_q == SHS_IDLE) begin
                done    <= 1'b0;
                failed  <= 1'b0;
                homed_q <= 1'b0;
            end else if (ref_take) begin
                done    <= 1'b1;
                homed_q <= 1'b1;
            end else if (fail_take) begin
                failed  <= 1'b1;
            end else if (lose_cmd) begin
                homed_q <= 1'b0;
                done    <= 1'b0;
            end
        end
    end

    // sticky events; a read clears only the bits it showed, a new event wins
    logic ev_rd;
    assign ev_rd  = avs_read && !avs_waitrequest && avs_address == REG_EVENT;
    assign ev_set = {task_cmd && !homed_q, mech_stop && state_q != SHS_IDLE,
                     fail_take, ref_take};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ev_q <= '0;
            irq  <= 1'b0;
        end else begin
            ev_q <= (ev_rd ? ev_q & ~avs_readdata[EV_W-1:0] : ev_q) | ev_set;
            irq  <= |(((ev_rd ? ev_q & ~avs_readdata[EV_W-1:0] : ev_q) | ev_set) & mask_q);
        end
    end

    // read data mux, registered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && rd_pend_q) begin
            unique case (rd_addr_q)
                REG_CTRL:   avs_readdata <= ctrl_q;
                REG_STATUS: avs_readdata <= {25'h0, state_q, homed_q, failed,
                                             done, busy};
                // effective threshold, so an unset word reads back as the default
                REG_THRESH: avs_readdata <= thresh;
                REG_HOMEP, REG_CAPA, REG_CAPB:
                            avs_readdata <= store_rd_q;
                REG_ILIM:   avs_readdata <= {16'h0, homing_current_limit};
                REG_EVENT:  avs_readdata <= {28'h0, ev_q};
                REG_MASK:   avs_readdata <= {28'h0, mask_q};
                REG_POS:    avs_readdata <= feedback_position;
                default:    avs_readdata <= 32'h0;
            endcase
        end
    end

    // RULE_07 reference loads home value next cycle
    pos_load_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
        ref_take |=> pos_load && commanded_position == $past(home_p))
        else $error("home value not loaded");
    task_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_14
        task_start |-> $past(homed_q))
        else $error("task started before homing");
    sequence s_back;
        state_q == SHS_BACK && mech_stop && !ix_q;
    endsequence
    stop_fail_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_02
        s_back ##1 1'b1 |=> failed)
        else $error("second stop did not fail");
    clamp_on_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_11
        (state_q == SHS_SEEK && mode == MODE_SWITCH) |=> current_clamp)
        else $error("current not clamped");
    done_set_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_15
        ref_take |=> done && decel_req)
        else $error("done not set on reference");
    rev_stop_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
        (state_q == SHS_SEEK && mode == MODE_STOP_INDEX && mech_stop && !ref_take)
        |=> move_dir != $past(move_dir) && state_q == SHS_BACK)
        else $error("no reversal at hard stop");
    rev_limit_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_08
        (state_q == SHS_SEEK && mode == MODE_INDEX && limit_hit && !reversed_q
         && !ix_q) |=> move_dir != $past(move_dir))
        else $error("no reversal at limit");
    sw_take_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_09
        (state_q == SHS_SEEK && mode == MODE_SWITCH && hs_rise && move_dir == dir_cfg)
        |=> pos_load)
        else $error("switch did not take reference");
endmodule : shs_sequencer
`default_nettype wire

// *** test/shs_motor_model.sv ***
// motor, encoder and switch model for the homing sequencer bench
// assumes the sequencer drives its motion outputs on ref_clk
`default_nettype none
module shs_motor_model (
    // clock and setup
    input  wire logic               ref_clk,
    input  wire logic               preset,
    input  wire logic               idx_on,
    input  wire logic signed [31:0] idx_at,
    input  wire logic signed [31:0] stop_at,
    input  wire logic signed [31:0] lim_at,
    input  wire logic signed [31:0] home_at,
    // motion from the sequencer
    input  wire logic               move_en,
    input  wire logic               move_dir,
    input  wire logic               decel_req,
    // feedback and switches
    output logic                    index_pulse,
    output logic             [31:0] following_error,
    output logic             [31:0] feedback_position,
    output logic                    at_standstill,
    output logic                    limit_pos,
    output logic                    limit_neg,
    output logic                    home_switch
);
    timeunit 1ns;
    timeprecision 1ps;
    int   pos_q;
    logic push;
    // a stalled shaft reports an error of 0x20000, far past the default threshold
    assign push = move_en && !decel_req && (move_dir ? pos_q >= stop_at : pos_q <= -stop_at);
    always_ff @(posedge ref_clk) begin
        if (preset) begin
            pos_q <= 0;
        end else if (move_en && !decel_req && !push) begin
            pos_q <= move_dir ? pos_q + 1 : pos_q - 1;
        end
    end
    assign index_pulse = idx_on && pos_q == idx_at;
    assign following_error = push ? 32'h0002_0000 : 32'h0000_0010;
    assign feedback_position = pos_q;
    // stops at once: the ramp itself is not modelled
    assign at_standstill = !move_en || decel_req;
    assign limit_pos = pos_q >= lim_at;
    assign limit_neg = pos_q <= -lim_at;
    assign home_switch = pos_q >= home_at && pos_q < home_at + 8;
endmodule : shs_motor_model
`default_nettype wire

// *** test/servo_homing_sequencer_tb_top.sv ***
// self-checking bench for the homing sequencer over its avalon-mm port
// assumes shs_motor_model on the far side
`default_nettype none
module servo_homing_sequencer_tb_top import shs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0, preset = 0, idx_on = 0;
    logic [3:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, following_error, feedback_position;
    logic [31:0] commanded_position, load_v, d;
    logic signed [31:0] ia = 0, sa = 999, la = 999, ha = 999;
    logic [15:0] homing_current_limit;
    logic [1:0] capture_unit_a_mode, capture_unit_b_mode;
    logic avs_waitrequest, index_pulse, at_standstill, limit_pos, limit_neg, home_switch;
    logic move_en, move_dir, decel_req, pos_load, current_clamp, task_start;
    logic busy, done, failed, irq, clamp_seen, dir0, moved;
    int n_mismatch = 0, comparisons = 0, n_load = 0, n_task = 0;
    shs_sequencer u_dut (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .index_pulse, .following_error, .feedback_position,
        .at_standstill, .limit_pos, .limit_neg, .home_switch, .move_en, .move_dir, .decel_req,
        .pos_load, .commanded_position, .homing_current_limit, .current_clamp, .task_start,
        .capture_unit_a_mode, .capture_unit_b_mode, .busy, .done, .failed, .irq);
    shs_motor_model u_motor (.ref_clk, .preset, .idx_on, .idx_at(ia), .stop_at(sa),
        .lim_at(la), .home_at(ha), .move_en, .move_dir, .decel_req, .index_pulse,
        .following_error, .feedback_position, .at_standstill, .limit_pos, .limit_neg,
        .home_switch);
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (pos_load) begin
            n_load++;
            load_v = commanded_position;
        end
        if (task_start) n_task++;
        if (current_clamp) clamp_seen = 1;
        if (move_en && !moved) begin
            moved = 1;
            dir0 = move_dir;
        end
    end
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(logic w, logic [3:0] a, logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        d = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
        if (n >= 100) begin
            n_mismatch++;
            close_out();
        end
    endtask : bus
    task automatic run(logic [3:0] m, logic dr, logic io, int i, int s, int l, int h, logic f);
        int n;
        @(posedge ref_clk);
        {idx_on, ia, sa, la, ha} <= {io, i, s, l, h};
        preset <= 1;
        @(posedge ref_clk);
        preset <= 0;
        {n_load, moved, clamp_seen} = '0;
        bus(1, REG_CTRL, (32'(m) << CTRL_MODE_LO) | (32'(dr) << CTRL_DIR) | 32'h1);
        // done from the previous run clears only once the start lands
        repeat (2) @(posedge ref_clk);
        for (n = 0; n < 3000 && !(done || failed); n++) @(posedge ref_clk);
        for (n = n; busy !== 1'b0 && n < 3000; n++) @(posedge ref_clk);
        if (n >= 3000) begin
            n_mismatch++;
            close_out();
        end
        chk("failed", failed, f);
        chk("done", done, !f);
        chk("loads", n_load, !f);
        if (!f) chk("home value", load_v, 32'h1234_5678);
        if (m != 4'h3) chk("first dir", dir0, dr);
    endtask : run
    task automatic task_req(int exp);
        bus(1, REG_CTRL, 32'h1 << CTRL_TASK);
        repeat (2) @(posedge ref_clk);
        chk("tasks", n_task, exp);
    endtask : task_req
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 0;
        chk("wait idle", avs_waitrequest, 1);
        chk("ilim", homing_current_limit, 16'h7fff);
        bus(0, REG_THRESH, 0);
        chk("thresh", d, RST_THRESH);
        bus(0, 4'hf, 0);
        chk("unmapped", d, 0);
        bus(1, REG_MASK, 32'hf);
        task_req(0);
        chk("irq set", irq, 1);
        bus(0, REG_EVENT, 0);
        chk("refused", d, 32'h1 << EV_REFUSE);
        repeat (2) @(posedge ref_clk);
        chk("irq clear", irq, 0);
        bus(1, REG_MASK, 0);
        task_req(0);
        chk("irq masked", irq, 0);
        bus(1, REG_CAPA, 32'(CAP_ON_INDEX));
        bus(1, REG_CAPB, 32'(CAP_ON_INDEX));
        bus(1, REG_ILIM, 32'h0000_0123);
        // capture outputs copy the stored words one edge after the write lands
        repeat (2) @(posedge ref_clk);
        chk("ilim set", homing_current_limit, 16'h0123);
        chk("cap", {capture_unit_a_mode, capture_unit_b_mode}, {2{CAP_ON_INDEX}});
        bus(1, REG_HOMEP, 32'h1234_5678);
        run(MODE_INDEX, 1, 1, 40, 999, 999, 999, 0);
        task_req(1);
        run(MODE_INDEX, 0, 1, -15, 999, 999, 999, 0);
        run(MODE_INDEX, 1, 1, -40, 999, 20, 999, 0);
        run(MODE_STOP_INDEX, 1, 1, -10, 30, 999, 999, 0);
        bus(0, REG_EVENT, 0);
        run(MODE_STOP_INDEX, 1, 0, 0, 30, 999, 999, 1);
        bus(0, REG_EVENT, 0);
        chk("events", d[3:0], 4'h6);
        run(MODE_SWITCH, 1, 0, 0, 999, 999, 10, 0);
        chk("clamp", clamp_seen, 1);
        run(MODE_SWITCH, 1, 0, 0, 30, 999, -25, 0);
        bus(1, REG_CTRL, 32'h1 << CTRL_LOSE);
        task_req(1);
        run(4'h3, 1, 0, 0, 999, 999, 999, 1);
        bus(0, REG_STATUS, 0);
        chk("status", d, 32'h0000_0004);
        close_out();
    end
endmodule : servo_homing_sequencer_tb_top
`default_nettype wire
